// ==== inc/gpom_defs.svh ====
// Purpose: Offsets, field positions and reset values of the pin output mux
// Assumes: Byte-wide registers at their printed byte addresses
// Notes: Definitions only
`ifndef GPOM_DEFS_SVH
`define GPOM_DEFS_SVH
`define GPOM_ADDR_W 8
`define GPOM_DATA_W 8
`define GPOM_PIN_TWO_OFS 8'h12
`define GPOM_PIN_THREE_OFS 8'h13
`define GPOM_PIN_STATUS_OFS 8'h20
`define GPOM_CTL_RESET 8'h00
`define GPOM_RD_RESET 8'h00
`define GPOM_SEL_MSB 7
`define GPOM_SEL_LSB 5
`define GPOM_SRC_MSB 4
`define GPOM_SRC_LSB 2
`define GPOM_VAL_BIT 1
`define GPOM_EN_BIT 0
`define GPOM_STS_TWO_LVL 0
`define GPOM_STS_TWO_OE 1
`define GPOM_STS_THREE_LVL 2
`define GPOM_STS_THREE_OE 3
`define GPOM_RX_PORTS 4
`define GPOM_TX_PORTS 2
`define GPOM_RX_GPIOS 16
`endif

// ==== inc/gpom_pkg.sv ====
// Purpose: Types of the pin output mux
// Assumes: Field layout matches the control register bit order
// Notes: Select codes differ by source
package gpom_pkg;
  typedef enum logic [2:0] {
    GPOM_SRC_RX0 = 3'h0,
    GPOM_SRC_RX1 = 3'h1,
    GPOM_SRC_RX2 = 3'h2,
    GPOM_SRC_RX3 = 3'h3,
    GPOM_SRC_DEV = 3'h4,
    GPOM_SRC_RSVD = 3'h5,
    GPOM_SRC_TX0 = 3'h6,
    GPOM_SRC_TX1 = 3'h7
  } gpom_src_t;
  typedef enum logic [2:0] {
    GPOM_DEV_VALUE = 3'h0,
    GPOM_DEV_LOCK_OR = 3'h1,
    GPOM_DEV_LOCK_AND = 3'h2,
    GPOM_DEV_PASS_AND = 3'h3,
    GPOM_DEV_FSYNC = 3'h4
  } gpom_dev_sel_t;
  typedef enum logic [2:0] {
    GPOM_TX_PASS_AND = 3'h0,
    GPOM_TX_PASS_OR = 3'h1,
    GPOM_TX_FV = 3'h2,
    GPOM_TX_LV = 3'h3,
    GPOM_TX_SYNCED = 3'h4,
    GPOM_TX_IRQ = 3'h5
  } gpom_tx_sel_t;
  typedef struct packed {
    logic [2:0] sel;
    gpom_src_t src;
    logic val;
    logic en;
  } gpom_pin_ctl_t;
  typedef struct packed {
    gpom_pin_ctl_t two;
    gpom_pin_ctl_t three;
    logic [7:0] rd_data;
    logic two_out;
    logic two_oe_b;
    logic three_out;
    logic three_oe_b;
  } gpom_state_t;
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] stable;
  } gpom_sync_t;
endpackage

// ==== verilog/gpom_sync.sv ====
// Purpose: Three-stage synchroniser for forwarded remote levels
// Assumes: Inputs are levels from another clock domain
// Notes: A bit changes once stages two and three agree
`timescale 1ns/1ps
module gpom_sync
  import gpom_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Levels
  input wire logic [15:0] i_async,
  output logic [15:0] o_sync
);
  gpom_sync_t st_reg;
  gpom_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Hold where the two late stages still disagree
    st_next.stable = (st_reg.s2 & st_reg.s3) | (st_reg.stable & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.stable;
endmodule // gpom_sync

// ==== verilog/gpom_pin_mux.sv ====
// Purpose: Source and select decode for one output pin
// Assumes: Status inputs are on the system clock
// Notes: Combinational; the top registers the result
`timescale 1ns/1ps
module gpom_pin_mux
  import gpom_pkg::*;
(
  // Pin control
  input wire gpom_pin_ctl_t i_ctl,
  // Receive port status
  input wire logic [15:0] i_rx_gpio,
  input wire logic [3:0] i_rx_lock,
  input wire logic [3:0] i_rx_pass,
  input wire logic [3:0] i_rx_fv,
  input wire logic [3:0] i_rx_lv,
  input wire logic [3:0] i_rx_port_en,
  // Device status
  input wire logic i_frame_sync,
  // Transmit port status
  input wire logic [3:0] i_tx0_rx_sel,
  input wire logic [3:0] i_tx1_rx_sel,
  input wire logic [1:0] i_tx_fv,
  input wire logic [1:0] i_tx_lv,
  input wire logic [1:0] i_tx_synced,
  input wire logic [1:0] i_tx_irq,
  // Result
  output logic o_level
);
  // Empty mask gives low, not a vacuous true
  function automatic logic masked_and(input logic [3:0] v, input logic [3:0] m);
    masked_and = (|m) & (&(v | ~m));
  endfunction

  function automatic logic masked_or(input logic [3:0] v, input logic [3:0] m);
    masked_or = |(v & m);
  endfunction

  logic [1:0] port;
  logic tx;
  logic [3:0] tx_mask;

  always_comb begin
    port = i_ctl.src[1:0];
    tx = i_ctl.src[0];
    tx_mask = tx ? i_tx1_rx_sel : i_tx0_rx_sel;
    o_level = 1'b0;
    unique case (i_ctl.src)
      GPOM_SRC_RX0, GPOM_SRC_RX1, GPOM_SRC_RX2, GPOM_SRC_RX3: begin
        unique case (i_ctl.sel)
          3'h0, 3'h1, 3'h2, 3'h3: o_level = i_rx_gpio[{port, i_ctl.sel[1:0]}]; // R2
          3'h4: o_level = i_rx_lock[port]; // R3
          3'h5: o_level = i_rx_pass[port]; // R3
          3'h6: o_level = i_rx_fv[port]; // R3
          3'h7: o_level = i_rx_lv[port]; // R3
        endcase
      end
      GPOM_SRC_DEV: begin
        case (i_ctl.sel)
          GPOM_DEV_VALUE: o_level = i_ctl.val; // R4
          GPOM_DEV_LOCK_OR: o_level = masked_or(i_rx_lock, i_rx_port_en); // R5
          GPOM_DEV_LOCK_AND: o_level = masked_and(i_rx_lock, i_rx_port_en); // R5
          GPOM_DEV_PASS_AND: o_level = masked_and(i_rx_pass, i_rx_port_en); // R5
          GPOM_DEV_FSYNC: o_level = i_frame_sync; // R6
          default: o_level = 1'b0; // R6
        endcase
      end
      GPOM_SRC_TX0, GPOM_SRC_TX1: begin
        case (i_ctl.sel)
          GPOM_TX_PASS_AND: o_level = masked_and(i_rx_pass, tx_mask); // R7
          GPOM_TX_PASS_OR: o_level = masked_or(i_rx_pass, tx_mask); // R7
          GPOM_TX_FV: o_level = i_tx_fv[tx]; // R8
          GPOM_TX_LV: o_level = i_tx_lv[tx]; // R8
          GPOM_TX_SYNCED: o_level = i_tx_synced[tx]; // R9
          GPOM_TX_IRQ: o_level = i_tx_irq[tx]; // R9
          default: o_level = 1'b0; // R9
        endcase
      end
      GPOM_SRC_RSVD: o_level = 1'b0; // R1
    endcase
  end
endmodule // gpom_pin_mux

// ==== verilog/gpom_top.sv ====
// Purpose: Output control of general-purpose pins two and three
// Assumes: Status inputs on i_clk_sys except forwarded remote levels
// Notes: Pin levels lag control and status by one clock, forwarded remote levels by five
// Behaviour
// [R1] Source field chooses receive, device or transmit
// [R2] Receive source selects forwarded remote levels
// [R3] Receive source selects lock, pass, frame, line
// [R4] Device select zero drives programmed value
// [R5] Device lock OR/AND, pass AND over enabled
// [R6] Device select four drives frame sync
// [R7] Transmit pass AND/OR over mapped ports
// [R8] Transmit frame and line valid
// [R9] Transmit synchronized and interrupt; rest reserved
// [R10] Value bit supplies locally controlled level
// [R11] Enable bit gates driver; fields reset zero
// [R12] Disabled pin stays undriven whatever selected
`timescale 1ns/1ps
`include "gpom_defs.svh"
module gpom_top
  import gpom_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_data,
  // Receive port status
  input wire logic [15:0] i_rx_gpio,
  input wire logic [3:0] i_rx_lock,
  input wire logic [3:0] i_rx_pass,
  input wire logic [3:0] i_rx_fv,
  input wire logic [3:0] i_rx_lv,
  input wire logic [3:0] i_rx_port_en,
  // Device status
  input wire logic i_frame_sync,
  // Transmit port status
  input wire logic [3:0] i_tx0_rx_sel,
  input wire logic [3:0] i_tx1_rx_sel,
  input wire logic [1:0] i_tx_fv,
  input wire logic [1:0] i_tx_lv,
  input wire logic [1:0] i_tx_synced,
  input wire logic [1:0] i_tx_irq,
  // Pin two
  output logic o_pin_two_out,
  output logic o_pin_two_oe_b,
  // Pin three
  output logic o_pin_three_out,
  output logic o_pin_three_oe_b
);
  gpom_state_t state_reg;
  gpom_state_t state_next;
  logic [15:0] rx_gpio_s;
  logic two_level;
  logic three_level;
  logic [7:0] status_rd;

  // Remote levels arrive on the link's recovered timing
  gpom_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(i_rx_gpio),
    .o_sync(rx_gpio_s)
  );

  gpom_pin_mux u_mux_two (
    .i_ctl(state_reg.two),
    .i_rx_gpio(rx_gpio_s),
    .i_rx_lock(i_rx_lock),
    .i_rx_pass(i_rx_pass),
    .i_rx_fv(i_rx_fv),
    .i_rx_lv(i_rx_lv),
    .i_rx_port_en(i_rx_port_en),
    .i_frame_sync(i_frame_sync),
    .i_tx0_rx_sel(i_tx0_rx_sel),
    .i_tx1_rx_sel(i_tx1_rx_sel),
    .i_tx_fv(i_tx_fv),
    .i_tx_lv(i_tx_lv),
    .i_tx_synced(i_tx_synced),
    .i_tx_irq(i_tx_irq),
    .o_level(two_level)
  );

  gpom_pin_mux u_mux_three (
    .i_ctl(state_reg.three),
    .i_rx_gpio(rx_gpio_s),
    .i_rx_lock(i_rx_lock),
    .i_rx_pass(i_rx_pass),
    .i_rx_fv(i_rx_fv),
    .i_rx_lv(i_rx_lv),
    .i_rx_port_en(i_rx_port_en),
    .i_frame_sync(i_frame_sync),
    .i_tx0_rx_sel(i_tx0_rx_sel),
    .i_tx1_rx_sel(i_tx1_rx_sel),
    .i_tx_fv(i_tx_fv),
    .i_tx_lv(i_tx_lv),
    .i_tx_synced(i_tx_synced),
    .i_tx_irq(i_tx_irq),
    .o_level(three_level)
  );

  always_comb begin
    status_rd = '0;
    status_rd[`GPOM_STS_TWO_LVL] = state_reg.two_out;
    status_rd[`GPOM_STS_TWO_OE] = ~state_reg.two_oe_b;
    status_rd[`GPOM_STS_THREE_LVL] = state_reg.three_out;
    status_rd[`GPOM_STS_THREE_OE] = ~state_reg.three_oe_b;
  end

  always_comb begin
    state_next = state_reg;
    // Register writes
    if (i_wr_stb && (i_addr == `GPOM_PIN_TWO_OFS)) begin
      state_next.two = gpom_pin_ctl_t'(i_wr_data);
    end
    if (i_wr_stb && (i_addr == `GPOM_PIN_THREE_OFS)) begin
      state_next.three = gpom_pin_ctl_t'(i_wr_data);
    end
    // Read data stands for one cycle only
    state_next.rd_data = `GPOM_RD_RESET;
    if (i_rd_stb) begin
      unique case (i_addr)
        `GPOM_PIN_TWO_OFS: state_next.rd_data = state_reg.two;
        `GPOM_PIN_THREE_OFS: state_next.rd_data = state_reg.three;
        `GPOM_PIN_STATUS_OFS: state_next.rd_data = status_rd;
        default: state_next.rd_data = `GPOM_RD_RESET;
      endcase
    end
    // Drivers; a disabled pin also parks its data low
    state_next.two_oe_b = ~state_reg.two.en; // R11
    state_next.two_out = state_reg.two.en & two_level; // R12 R10 R1
    state_next.three_oe_b = ~state_reg.three.en; // R11
    state_next.three_out = state_reg.three.en & three_level; // R12 R10 R1
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg.two <= gpom_pin_ctl_t'(`GPOM_CTL_RESET); // R11
      state_reg.three <= gpom_pin_ctl_t'(`GPOM_CTL_RESET); // R11
      state_reg.rd_data <= `GPOM_RD_RESET;
      state_reg.two_out <= 1'b0;
      state_reg.two_oe_b <= 1'b1; // R12
      state_reg.three_out <= 1'b0;
      state_reg.three_oe_b <= 1'b1; // R12
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rd_data = state_reg.rd_data;
  assign o_pin_two_out = state_reg.two_out;
  assign o_pin_two_oe_b = state_reg.two_oe_b;
  assign o_pin_three_out = state_reg.three_out;
  assign o_pin_three_oe_b = state_reg.three_oe_b;

  // Checks on pin two; pin three shares the same mux
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  logic [2:0] src2;
  logic [2:0] sel2;
  logic en2;
  assign src2 = state_reg.two.src;
  assign sel2 = state_reg.two.sel;
  assign en2 = state_reg.two.en;

  a_reserved_src_low: assert property ( // R1
    (en2 && src2 == 3'h5) |=> !o_pin_two_out && !o_pin_two_oe_b)
    else $error("reserved source did not drive low");

  a_rx_gpio_route: assert property ( // R2
    (en2 && !src2[2] && !sel2[2]) |=> o_pin_two_out == $past(rx_gpio_s[{src2[1:0], sel2[1:0]}]))
    else $error("remote level not routed to pin");

  a_rx_lock_route: assert property ( // R3
    (en2 && !src2[2] && sel2 == 3'h4) |=> o_pin_two_out == $past(i_rx_lock[src2[1:0]]))
    else $error("lock indication not routed to pin");

  a_rx_line_route: assert property ( // R3
    (en2 && !src2[2] && sel2 == 3'h7) |=> o_pin_two_out == $past(i_rx_lv[src2[1:0]]))
    else $error("line valid not routed to pin");

  a_dev_value_route: assert property ( // R4
    (en2 && src2 == 3'h4 && sel2 == 3'h0) |=> o_pin_two_out == $past(state_reg.two.val))
    else $error("programmed value not on pin");

  a_value_write_pin: assert property ( // R10
    (i_wr_stb && i_addr == `GPOM_PIN_TWO_OFS && i_wr_data[7:2] == 6'h04 && i_wr_data[0])
    |=> ##1 o_pin_two_out == $past(i_wr_data[1], 2) && !o_pin_two_oe_b)
    else $error("written value not driven two cycles later");

  a_dev_lock_and: assert property ( // R5
    (en2 && src2 == 3'h4 && sel2 == 3'h2)
    |=> o_pin_two_out == $past((|i_rx_port_en) && (&(i_rx_lock | ~i_rx_port_en))))
    else $error("lock AND over enabled ports wrong");

  a_dev_fsync_route: assert property ( // R6
    (en2 && src2 == 3'h4 && sel2 == 3'h4) |=> o_pin_two_out == $past(i_frame_sync))
    else $error("frame sync not routed to pin");

  a_dev_reserved_low: assert property ( // R6
    (en2 && src2 == 3'h4 && sel2 > 3'h4) |=> !o_pin_two_out)
    else $error("reserved device select drove high");

  a_tx_pass_or: assert property ( // R7
    (en2 && src2 == 3'h7 && sel2 == 3'h1) |=> o_pin_two_out == $past(|(i_rx_pass & i_tx1_rx_sel)))
    else $error("transmit pass OR wrong");

  a_tx_frame_route: assert property ( // R8
    (en2 && src2 == 3'h6 && sel2 == 3'h2) |=> o_pin_two_out == $past(i_tx_fv[0]))
    else $error("transmit frame valid not routed");

  a_tx_irq_route: assert property ( // R9
    (en2 && src2 == 3'h7 && sel2 == 3'h5) |=> o_pin_two_out == $past(i_tx_irq[1]))
    else $error("transmit interrupt not routed");

  a_enable_write_drv: assert property ( // R11
    (i_wr_stb && i_addr == `GPOM_PIN_TWO_OFS) |=> ##1 o_pin_two_oe_b == !$past(i_wr_data[0], 2))
    else $error("enable bit did not reach driver");

  a_disabled_undriven: assert property ( // R12
    (!en2) [*2] |-> o_pin_two_oe_b && !o_pin_two_out)
    else $error("disabled pin was driven");

  a_read_unmapped_zero: assert property (
    (i_rd_stb && i_addr != `GPOM_PIN_TWO_OFS && i_addr != `GPOM_PIN_THREE_OFS
      && i_addr != `GPOM_PIN_STATUS_OFS) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");

  a_read_ctl_two: assert property (
    (i_rd_stb && i_addr == `GPOM_PIN_TWO_OFS) |=> o_rd_data == $past(state_reg.two))
    else $error("control read returned wrong value");

  c_rx_gpio_on_pin: cover property (en2 && !src2[2] && !sel2[2] ##1 o_pin_two_out);
  c_dev_fsync_on_pin: cover property (en2 && src2 == 3'h4 && sel2 == 3'h4 ##1 o_pin_two_out);
  c_tx_pass_and_high: cover property (en2 && src2 == 3'h6 && sel2 == 3'h0 ##1 o_pin_two_out);
  c_pin_released: cover property (!o_pin_two_oe_b ##1 o_pin_two_oe_b);
endmodule // gpom_top

// ==== dv/gpom_pin_sampler.sv ====
// Purpose: Far-side logic sampling one general-purpose output pin
// Assumes: Active-low output enable, no pull on the wire
// Notes: An undriven wire shows a level that flips every cycle
`timescale 1ns/1ps
module gpom_pin_sampler (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Pin
  input wire logic i_pin_out,
  input wire logic i_pin_oe_b,
  // Seen by the far side
  output logic o_level,
  output logic o_driven
);
  logic last_reg;
  // Floating wire must never pass for a held level
  assign o_driven = (i_pin_oe_b === 1'b0);
  assign o_level = o_driven ? i_pin_out : ~last_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= o_level;
    end
  end
endmodule // gpom_pin_sampler

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the pin output mux
// Assumes: Status inputs held steady while a control code is checked
// Notes: Every source and select code is swept on pin two per status row
`timescale 1ns/1ps
`include "gpom_defs.svh"
module testbench
  import gpom_pkg::*;
;
  typedef struct {
    logic [15:0] gpio;
    logic [3:0] lock, pass, fv, lv, en, m0, m1;
    logic [1:0] tfv, tlv, syn, irq;
    logic fs;
  } gpom_tb_row_t;
  logic clk, rst_b, wr, rd;
  logic [7:0] addr, wdata, rdata, b;
  logic two_out, two_oe_b, three_out, three_oe_b;
  logic two_lvl, two_drv, three_lvl, three_drv;
  int miscompares, comparisons;
  gpom_tb_row_t rows [3];
  gpom_tb_row_t cur;

  gpom_top u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wdata), .i_wr_stb(wr),
    .i_rd_stb(rd), .o_rd_data(rdata), .i_rx_gpio(cur.gpio), .i_rx_lock(cur.lock), .i_rx_pass(cur.pass),
    .i_rx_fv(cur.fv), .i_rx_lv(cur.lv), .i_rx_port_en(cur.en), .i_frame_sync(cur.fs),
    .i_tx0_rx_sel(cur.m0), .i_tx1_rx_sel(cur.m1), .i_tx_fv(cur.tfv), .i_tx_lv(cur.tlv),
    .i_tx_synced(cur.syn), .i_tx_irq(cur.irq), .o_pin_two_out(two_out), .o_pin_two_oe_b(two_oe_b),
    .o_pin_three_out(three_out), .o_pin_three_oe_b(three_oe_b));
  gpom_pin_sampler u_far_two (.i_clk_sys(clk), .i_rst_b(rst_b), .i_pin_out(two_out),
    .i_pin_oe_b(two_oe_b), .o_level(two_lvl), .o_driven(two_drv));
  gpom_pin_sampler u_far_three (.i_clk_sys(clk), .i_rst_b(rst_b), .i_pin_out(three_out),
    .i_pin_oe_b(three_oe_b), .o_level(three_lvl), .o_driven(three_drv));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Caller stands just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask

  // Empty masks give 0; reserved codes give 0 with the driver on
  function automatic logic exp_lvl(input logic [7:0] c, input gpom_tb_row_t s);
    logic [2:0] sel;
    logic [2:0] src;
    logic [3:0] m;
    logic t;
    sel = c[7:5];
    src = c[4:2];
    t = src[0];
    m = t ? s.m1 : s.m0;
    if (c[0] == 1'b0) return 1'b0;
    if (src < 3'h4) begin
      case (sel)
        3'h4: return s.lock[src[1:0]];
        3'h5: return s.pass[src[1:0]];
        3'h6: return s.fv[src[1:0]];
        3'h7: return s.lv[src[1:0]];
        default: return s.gpio[{src[1:0], sel[1:0]}];
      endcase
    end
    if (src == 3'h4) begin
      case (sel)
        3'h0: return c[1];
        3'h1: return |(s.lock & s.en);
        3'h2: return (s.en != 4'h0) && ((s.lock & s.en) == s.en);
        3'h3: return (s.en != 4'h0) && ((s.pass & s.en) == s.en);
        3'h4: return s.fs;
        default: return 1'b0;
      endcase
    end
    if (src == 3'h5) return 1'b0;
    case (sel)
      3'h0: return (m != 4'h0) && ((s.pass & m) == m);
      3'h1: return |(s.pass & m);
      3'h2: return s.tfv[t];
      3'h3: return s.tlv[t];
      3'h4: return s.syn[t];
      3'h5: return s.irq[t];
      default: return 1'b0;
    endcase
  endfunction

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    // Watchdog well beyond the roughly 650 cycles the run needs
    #200000;
    miscompares++;
    stop_test;
  end

  initial begin
    rows[0] = '{16'ha5c3, 4'h5, 4'h3, 4'h9, 4'h6, 4'hf, 4'h3, 4'h6, 2'h1, 2'h2, 2'h2, 2'h1, 1'b1};
    rows[1] = '{16'h5a3c, 4'h5, 4'hc, 4'h6, 4'h9, 4'h0, 4'h0, 4'hc, 2'h2, 2'h1, 2'h1, 2'h2, 1'b0};
    rows[2] = '{16'hffff, 4'hf, 4'hf, 4'hf, 4'hf, 4'h5, 4'hf, 4'h1, 2'h3, 2'h3, 2'h3, 2'h3, 1'b1};
    cur = rows[0];
    clk = 1'b0;
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(`GPOM_PIN_TWO_OFS, 8'h00);
    rd_reg(`GPOM_PIN_THREE_OFS, 8'h00);
    chk("two driven after reset", 8'h00, two_drv);
    chk("three driven after reset", 8'h00, three_drv);
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      cur <= rows[r];
      // Remote levels need the synchroniser to settle
      repeat (6) @(posedge clk);
      for (int c = 0; c < 64; c++) begin
        b = {c[5:0], c[0] ^ c[3], 1'b1};
        wr_reg(`GPOM_PIN_TWO_OFS, b);
        repeat (2) @(posedge clk);
        #1;
        chk("two level", exp_lvl(b, rows[r]), two_lvl);
        chk("two driven", 8'h01, two_drv);
      end
    end
    @(posedge clk);
    wr_reg(`GPOM_PIN_THREE_OFS, 8'h12);
    repeat (2) @(posedge clk);
    #1;
    chk("three driven while disabled", 8'h00, three_drv);
    chk("three out while disabled", 8'h00, three_out);
    wr_reg(`GPOM_PIN_THREE_OFS, 8'h13);
    rd_reg(`GPOM_PIN_THREE_OFS, 8'h13);
    @(posedge clk);
    #1;
    chk("read data after its cycle", 8'h00, rdata);
    repeat (2) @(posedge clk);
    #1;
    chk("three level", 8'h01, three_lvl);
    rd_reg(`GPOM_PIN_STATUS_OFS, 8'h0e);
    wr_reg(8'h55, 8'hff);
    rd_reg(8'h55, 8'h00);
    wr_reg(`GPOM_PIN_STATUS_OFS, 8'hff);
    rd_reg(`GPOM_PIN_STATUS_OFS, 8'h0e);
    rd_reg(`GPOM_PIN_TWO_OFS, {6'h3f, 2'h1});
    // Release pin two so its driver is seen to let go
    wr_reg(`GPOM_PIN_TWO_OFS, 8'hfc);
    repeat (2) @(posedge clk);
    #1;
    chk("two driven while disabled", 8'h00, two_drv);
    chk("two out while disabled", 8'h00, two_out);
    // Reset again in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("three driven in reset", 8'h00, three_drv);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(`GPOM_PIN_THREE_OFS, 8'h00);
    stop_test;
  end
endmodule // testbench
